// ---- hdl/uar_baud_gen.sv ----
/*
  baud generator: one-cycle tick at sixteen times the bit rate.
  assumes the divider and speed select are held stable while run is high.
*/
`timescale 1ns/1ns
module uar_baud_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] divisor,
  input wire logic high_speed,
  output logic tick
);
  import uar_pkg::*;

  logic [7:0] div_cnt;
  logic [1:0] pre_cnt;
  logic [7:0] next_div_cnt;
  logic [1:0] next_pre_cnt;
  logic next_tick;

  // ----------------------------------------------------------------------
  // divider: period divisor+1, then by four unless high speed
  // ----------------------------------------------------------------------
  always_comb begin
    next_div_cnt = div_cnt + 8'h01;
    next_pre_cnt = pre_cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_div_cnt = 8'h00;
      next_pre_cnt = 2'h0;
    end else if (div_cnt == divisor) begin
      next_div_cnt = 8'h00;
      next_pre_cnt = pre_cnt + 2'h1;
      next_tick = high_speed || (pre_cnt == LOW_PRE_LAST);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 8'h00;
      pre_cnt <= 2'h0;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      pre_cnt <= next_pre_cnt;
      tick <= next_tick;
    end
  end
endmodule : uar_baud_gen

// ---- hdl/uar_pkg.sv ----
/*
  constants for the asynchronous serial receiver: register indices, bit
  positions, reset values and line timing.
  assumes a 100 MHz ref_clk and a 32-bit APB slave port.
*/
package uar_pkg;
  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PIR = 8'h0C;
  localparam logic [7:0] IDX_RCS = 8'h18;
  localparam logic [7:0] IDX_TXB = 8'h19;
  localparam logic [7:0] IDX_RXB = 8'h1A;
  localparam logic [7:0] IDX_PIE = 8'h8C;
  localparam logic [7:0] IDX_TXS = 8'h98;
  localparam logic [7:0] IDX_BRG = 8'h99;
  localparam int APB_AW = 12;

  // ----------------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------------
  localparam int B_RX_DONE = 5;   // flag and enable share this position
  localparam int B_PORT_EN = 7;
  localparam int B_NINE_SEL = 6;
  localparam int B_SINGLE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_ADDR_DET = 3;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_NINTH = 0;
  localparam int B_SYNC = 4;
  localparam int B_HIGH_BAUD = 2;
  localparam int B_SHIFT_EMPTY = 1;
  localparam logic [7:0] RCS_WMASK = 8'hF8;
  localparam logic [7:0] TXS_WMASK = 8'hF5;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_TXS = 8'h02;
  localparam logic [3:0] SMP_LAST = 4'hF;   // sixteen samples per bit
  localparam logic [3:0] SMP_MID = 4'h9;    // majority of samples 7,8,9
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [1:0] LOW_PRE_LAST = 2'h3; // x64 generator = x16 by 4
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uar_state_e;
endpackage : uar_pkg

// ---- hdl/uar_receiver.sv ----
/*
  asynchronous serial receiver with its register file on APB.
  assumes rx_pin is asynchronous to ref_clk and sleep_req is on ref_clk.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ns
module uar_receiver (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uar_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic sleep_req,
  output logic rx_irq
);
  import uar_pkg::*;

  function automatic logic [APB_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction : byte_addr

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] pie, rcs_ctl, txs_ctl, txb, brg;
  logic [7:0] next_pie, next_rcs_ctl, next_txs_ctl, next_txb, next_brg;
  logic overrun, next_overrun;
  logic [9:0] fifo_mem [0:1];   // {frame error, ninth, data}
  logic [9:0] next_mem0, next_mem1;
  logic [1:0] fifo_cnt, next_fifo_cnt;
  logic rd_ptr, next_rd_ptr;
  logic rx_m, rx_s, rx_prev, next_rx_prev;
  uar_state_e state, next_state;
  logic [3:0] smp_cnt, next_smp_cnt;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [2:0] smp, next_smp;
  logic [8:0] shreg, next_shreg;
  logic tick, rx_en, maj, push, pop, frame_done, stop_ok;
  logic [9:0] word;
  logic [9:0] head;
  logic [7:0] rcs_rd, pir_rd;
  logic next_rx_irq;

  // ----------------------------------------------------------------------
  // line synchroniser: only the second flop is read by logic
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= rx_pin;
      rx_s <= rx_m;
    end
  end

  // receiver runs only in async mode, port on, continuous receive, awake
  assign rx_en = rcs_ctl[B_PORT_EN] && !txs_ctl[B_SYNC]
    && rcs_ctl[B_CONT_RX] && !sleep_req;

  uar_baud_gen u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(rx_en),
    .divisor(brg),
    .high_speed(txs_ctl[B_HIGH_BAUD]),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // frame recovery
  // ----------------------------------------------------------------------
  assign maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
  assign frame_done = tick && rx_en && (state == ST_STOP) && (smp_cnt == SMP_MID);
  assign stop_ok = maj;
  // nine-bit frames keep ninth bit on top; eight-bit frames shift one more
  assign word = rcs_ctl[B_NINE_SEL] ? {!stop_ok, shreg[8], shreg[7:0]}
    : {!stop_ok, 1'b0, shreg[8:1]};

  // state machine steps once per x16 tick
  always_comb begin
    next_state = state;
    next_smp_cnt = smp_cnt;
    next_bit_cnt = bit_cnt;
    next_smp = smp;
    next_shreg = shreg;
    next_rx_prev = rx_prev;
    if (!rx_en) begin
      next_state = ST_IDLE;
      next_rx_prev = 1'b1;
    end else if (tick) begin
      next_smp = {smp[1:0], rx_s};
      next_smp_cnt = smp_cnt + 4'h1;
      next_rx_prev = rx_s;
      unique case (state)
        ST_IDLE: begin
          if (rx_prev && !rx_s) begin
            next_state = ST_START;
            next_smp_cnt = 4'h1;
          end
        end
        ST_START: begin
          if (smp_cnt == SMP_MID && maj) begin
            next_state = ST_IDLE; // glitch, not a start bit
          end else if (smp_cnt == SMP_LAST) begin
            next_state = ST_DATA;
            next_bit_cnt = 4'h0;
          end
        end
        ST_DATA: begin
          if (smp_cnt == SMP_MID) begin
            next_shreg = {maj, shreg[8:1]};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (smp_cnt == SMP_LAST && bit_cnt == (rcs_ctl[B_NINE_SEL] ? BITS9 : BITS8)) begin
            next_state = ST_STOP;
          end
        end
        ST_STOP: begin
          if (smp_cnt == SMP_MID) begin
            next_state = ST_IDLE; // stop bit judged, look for next start
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      smp_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      smp <= 3'h7;
      shreg <= 9'h000;
      rx_prev <= 1'b1;
    end else begin
      state <= next_state;
      smp_cnt <= next_smp_cnt;
      bit_cnt <= next_bit_cnt;
      smp <= next_smp;
      shreg <= next_shreg;
      rx_prev <= next_rx_prev;
    end
  end

  // ----------------------------------------------------------------------
  // receive fifo and overrun
  // ----------------------------------------------------------------------
  logic apb_done, rd_ok, next_rd_ok, addr_drop;
  assign apb_done = psel && penable && pready;
  assign addr_drop = rcs_ctl[B_ADDR_DET] && rcs_ctl[B_NINE_SEL] && !word[8];
  assign push = frame_done && !overrun && !addr_drop
    && (fifo_cnt != FIFO_DEPTH);
  assign pop = apb_done && !pwrite && (paddr == byte_addr(IDX_RXB)) && rd_ok;
  assign head = fifo_mem[rd_ptr];

  // push and pop in one cycle keep the count; a word arriving while full is dropped, even with a pop
  always_comb begin
    next_mem0 = fifo_mem[0];
    next_mem1 = fifo_mem[1];
    next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};
    next_rd_ptr = pop ? !rd_ptr : rd_ptr;
    next_overrun = overrun;
    if (push) begin
      if ((rd_ptr ^ (fifo_cnt != 2'h0)) == 1'b0) begin
        next_mem0 = word;
      end else begin
        next_mem1 = word;
      end
    end
    if (!rcs_ctl[B_CONT_RX]) begin
      next_overrun = 1'b0;
    end else if (frame_done && !overrun && !addr_drop && fifo_cnt == FIFO_DEPTH) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fifo_mem[0] <= 10'h000;
      fifo_mem[1] <= 10'h000;
      fifo_cnt <= 2'h0;
      rd_ptr <= 1'b0;
      overrun <= 1'b0;
    end else begin
      fifo_mem[0] <= next_mem0;
      fifo_mem[1] <= next_mem1;
      fifo_cnt <= next_fifo_cnt;
      rd_ptr <= next_rd_ptr;
      overrun <= next_overrun;
    end
  end

  // ----------------------------------------------------------------------
  // register file and APB slave, one wait state per transfer
  // ----------------------------------------------------------------------
  assign pir_rd = {2'b00, (fifo_cnt != 2'h0), 5'h00};
  assign rcs_rd = {rcs_ctl[7:3], head[9], overrun, head[8]};

  logic [31:0] rd_data, next_prdata;
  logic hit, next_pready, next_pslverr;
  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr)
      byte_addr(IDX_PIR): rd_data[7:0] = pir_rd;
      byte_addr(IDX_RCS): rd_data[7:0] = rcs_rd;
      byte_addr(IDX_TXB): rd_data[7:0] = txb;
      byte_addr(IDX_RXB): rd_data[7:0] = head[7:0];
      byte_addr(IDX_PIE): rd_data[7:0] = pie;
      byte_addr(IDX_TXS): rd_data[7:0] = txs_ctl | RST_TXS; // no transmitter: shift reg empty
      byte_addr(IDX_BRG): rd_data[7:0] = brg;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_rd_ok = rd_ok;
    next_pie = pie;
    next_rcs_ctl = rcs_ctl;
    next_txs_ctl = txs_ctl;
    next_txb = txb;
    next_brg = brg;
    if (psel && penable && !pready) begin
      next_prdata = pwrite ? 32'h0000_0000 : rd_data;
      next_pslverr = !hit;
      next_rd_ok = fifo_cnt != 2'h0;   // pop only a word actually returned
    end
    if (apb_done && pwrite) begin
      unique case (paddr)
        byte_addr(IDX_RCS): next_rcs_ctl = pwdata[7:0] & RCS_WMASK;
        byte_addr(IDX_TXB): next_txb = pwdata[7:0];
        byte_addr(IDX_PIE): next_pie = pwdata[7:0];
        byte_addr(IDX_TXS): next_txs_ctl = pwdata[7:0] & TXS_WMASK;
        byte_addr(IDX_BRG): next_brg = pwdata[7:0];
        default: next_brg = brg;   // read-only or unmapped: no effect
      endcase
    end
    next_rx_irq = (fifo_cnt != 2'h0) && pie[B_RX_DONE];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_ok <= 1'b0;
      pie <= RST_BYTE;
      rcs_ctl <= RST_BYTE;
      txs_ctl <= RST_BYTE;
      txb <= RST_BYTE;
      brg <= RST_BYTE;
      rx_irq <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      rd_ok <= next_rd_ok;
      pie <= next_pie;
      rcs_ctl <= next_rcs_ctl;
      txs_ctl <= next_txs_ctl;
      txb <= next_txb;
      brg <= next_brg;
      rx_irq <= next_rx_irq;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_RX_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    !rx_en |=> state == ST_IDLE) else $error("receiver active while disabled");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
    rx_irq == $past(fifo_cnt != 2'h0 && pie[B_RX_DONE])) else $error("irq not gated");
  AST_FIFO: assert property (@(posedge ref_clk) disable iff (rst)
    fifo_cnt <= FIFO_DEPTH) else $error("fifo count beyond two");
  AST_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
    pop && fifo_cnt == 2'h1 && !push |=> fifo_cnt == 2'h0 && pir_rd[B_RX_DONE] == 1'b0)
    else $error("flag not cleared on empty");
  AST_OVR_SET: assert property (@(posedge ref_clk) disable iff (rst)
    frame_done && !overrun && !addr_drop && fifo_cnt == FIFO_DEPTH && rcs_ctl[B_CONT_RX]
    |=> overrun && fifo_cnt == $past(fifo_cnt) - {1'b0, $past(pop)}) else $error("no overrun");
  AST_OVR_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    overrun && rcs_ctl[B_CONT_RX] |=> overrun) else $error("overrun cleared early");
  AST_OVR_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
    overrun |-> !push) else $error("transfer while overrun");
  AST_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    frame_done && rcs_ctl[B_ADDR_DET] && rcs_ctl[B_NINE_SEL] && !word[8] |-> !push)
    else $error("data frame accepted in address mode");
  AST_PUSH: assert property (@(posedge ref_clk) disable iff (rst)
    push && !pop |=> fifo_cnt == $past(fifo_cnt) + 2'h1 && pir_rd[B_RX_DONE])
    else $error("word not transferred");
  AST_APB: assert property (@(posedge ref_clk) disable iff (rst)
    psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer late");
endmodule : uar_receiver

// ---- verif/uar_line_tx.sv ----
/*
  model of the remote serial transmitter that drives the receive line.
  assumes the bench calls send with a bit time given in ref_clk cycles.
*/
`timescale 1ns/1ns
module uar_line_tx (
  input wire logic ref_clk,
  output logic rx_line
);
  // ----------------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------------
  // the line idles high, so an undriven gap never looks like a start bit
  initial rx_line = 1'b1;

  // start, data lsb first, stop, then one idle bit time
  // the idle bit gives a clean falling edge even after a bad stop bit
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_bit,
                      input int bclk);
    int nb;
    logic b;
    nb = nine ? 9 : 8;
    for (int i = 0; i < nb + 3; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stop_bit : 1'b1;
      @(posedge ref_clk);
      rx_line <= b;
      repeat (bclk - 1) @(posedge ref_clk);
    end
  endtask : send
endmodule : uar_line_tx

// ---- verif/uart_async_receiver_tb.sv ----
/*
  self-checking bench for the serial receiver: APB master, line model.
  assumes the APB slave answers with a registered pready.
*/
`timescale 1ns/1ns
module uart_async_receiver_tb;
  import uar_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, sleep_req, rx_pin, pready, pslverr, rx_irq, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors, checks;

  uar_receiver DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .sleep_req(sleep_req), .rx_irq(rx_irq)
  );
  uar_line_tx tx (.ref_clk(ref_clk), .rx_line(rx_pin));

  // ----------------------------------------------------------------------
  // clock and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one APB transfer; the request holds until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask : rchk

  // margin after a frame: flag one cycle, irq one more
  task settle;
    repeat (4) @(posedge ref_clk);
  endtask : settle

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    rchk("pir", IDX_PIR, RST_BYTE);
    rchk("rcs", IDX_RCS, RST_BYTE);
    rchk("txb", IDX_TXB, RST_BYTE);
    rchk("rxb", IDX_RXB, RST_BYTE);
    rchk("pie", IDX_PIE, RST_BYTE);
    rchk("txs", IDX_TXS, RST_TXS);
    rchk("brg", IDX_BRG, RST_BYTE);
    chk("slverr_ok", 32'h0, {31'h0, err});
    apb(1'b0, 8'h20, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
  endtask : t_reset

  // bit time 16 clocks: divider 0 with the fast select
  task t_basic;
    wr(IDX_BRG, 8'h00);
    wr(IDX_TXS, 8'h04);
    wr(IDX_RCS, 8'h90);
    tx.send(9'h0A5, 1'b0, 1'b1, 16);
    settle;
    chk("irq_masked", 32'h0, {31'h0, rx_irq});
    rchk("rx_flag", IDX_PIR, 8'h20);
    wr(IDX_PIR, 8'h00);
    rchk("rx_flag_ro", IDX_PIR, 8'h20);
    wr(IDX_PIE, 8'h20);
    settle;
    chk("irq", 32'h1, {31'h0, rx_irq});
    rchk("rcs", IDX_RCS, 8'h90);
    rchk("data", IDX_RXB, 8'hA5);
    settle;
    rchk("rx_flag_clr", IDX_PIR, 8'h00);
    chk("irq_clr", 32'h0, {31'h0, rx_irq});
  endtask : t_basic

  task t_fifo;
    tx.send(9'h011, 1'b0, 1'b1, 16);
    tx.send(9'h022, 1'b0, 1'b1, 16);
    tx.send(9'h033, 1'b0, 1'b1, 16);
    settle;
    rchk("overrun", IDX_RCS, 8'h92);
    rchk("first", IDX_RXB, 8'h11);
    rchk("second", IDX_RXB, 8'h22);
    tx.send(9'h044, 1'b0, 1'b1, 16);
    settle;
    rchk("blocked", IDX_PIR, 8'h00);
    wr(IDX_RCS, 8'h90);
    rchk("overrun_stays", IDX_RCS, 8'h92);
    wr(IDX_RCS, 8'h80);
    wr(IDX_RCS, 8'h90);
    rchk("overrun_clr", IDX_RCS, 8'h90);
    tx.send(9'h055, 1'b0, 1'b1, 16);
    settle;
    rchk("after", IDX_RXB, 8'h55);
  endtask : t_fifo

  // status of each word follows it through the queue
  task t_ninth;
    wr(IDX_RCS, 8'hD0);
    tx.send(9'h13C, 1'b1, 1'b1, 16);
    tx.send(9'h05A, 1'b1, 1'b0, 16);
    settle;
    rchk("ninth", IDX_RCS, 8'hD1);
    rchk("d1", IDX_RXB, 8'h3C);
    rchk("frame_err", IDX_RCS, 8'hD4);
    rchk("d2", IDX_RXB, 8'h5A);
  endtask : t_ninth

  task t_addr;
    wr(IDX_RCS, 8'hD8);
    tx.send(9'h077, 1'b1, 1'b1, 16);
    settle;
    rchk("drop", IDX_PIR, 8'h00);
    tx.send(9'h1A1, 1'b1, 1'b1, 16);
    settle;
    rchk("addr", IDX_RXB, 8'hA1);
    wr(IDX_RCS, 8'hD0);
    tx.send(9'h066, 1'b1, 1'b1, 16);
    settle;
    rchk("data_word", IDX_RXB, 8'h66);
  endtask : t_addr

  task t_gate;
    wr(IDX_RCS, 8'h80);
    tx.send(9'h012, 1'b0, 1'b1, 16);
    settle;
    rchk("off", IDX_PIR, 8'h00);
    wr(IDX_RCS, 8'h90);
    sleep_req <= 1'b1;
    tx.send(9'h034, 1'b0, 1'b1, 16);
    settle;
    rchk("sleep", IDX_PIR, 8'h00);
    sleep_req <= 1'b0;
  endtask : t_gate

  // slow select: tick = 4 * (1 + 1) clocks, bit = 128 clocks
  task t_slow;
    wr(IDX_BRG, 8'h01);
    wr(IDX_TXS, 8'h00);
    tx.send(9'h0C5, 1'b0, 1'b1, 128);
    settle;
    rchk("slow", IDX_RXB, 8'hC5);
  endtask : t_slow

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_fifo();
    t_ninth();
    t_addr();
    t_gate();
    t_slow();
    results();
  end
endmodule : uart_async_receiver_tb
